// File: src/dcf_top.sv
// Two-port clocked FIFO with mailboxes and synchronised status flags
`timescale 1ns/1ns
`default_nettype none
module dcf_top #(
    parameter int unsigned DEPTH = dcf_pkg::DEPTH_DEFAULT,
    parameter int unsigned STAGE = dcf_pkg::STAGE_DEPTH,
    localparam int unsigned AW   = $clog2(DEPTH),
    localparam int unsigned PW   = AW + 1,
    localparam int unsigned DW   = dcf_pkg::DATA_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    // Port A controls and data
    input  wire logic          port_a_chip_select_n,
    input  wire logic          port_a_write_not_read,
    input  wire logic          port_a_enable,
    input  wire logic          port_a_mailbox_select,
    input  wire logic [DW-1:0] a_data_in,
    output var  logic [DW-1:0] a_data_out,
    output var  logic          a_data_oe,
    // Port B controls and data
    input  wire logic          port_b_chip_select_n,
    input  wire logic          port_b_read_not_write,
    input  wire logic          port_b_enable,
    input  wire logic          port_b_mailbox_select,
    input  wire logic [DW-1:0] b_data_in,
    output var  logic [DW-1:0] b_data_out,
    output var  logic          b_data_oe,
    // Flag offsets
    input  wire logic [PW-1:0] almost_empty_offset,
    input  wire logic [PW-1:0] almost_full_offset,
    // Status flags
    output var  logic          input_ready_flag,
    output var  logic          output_ready_flag,
    output var  logic          almost_empty_flag_n,
    output var  logic          almost_full_flag_n,
    output var  logic          first_mail_flag_n,
    output var  logic          second_mail_flag_n
);
    // ==========================================================
    // Parameter check
    if (DEPTH != 512 && DEPTH != 1024 && DEPTH != 2048) begin : g_bad_depth
        $error("dcf_top: DEPTH must be 512, 1024 or 2048");
    end

    // ==========================================================
    // Helpers
    // Words between two wrapping pointers
    function automatic logic [PW-1:0] fill_level(input logic [PW-1:0] wp,
                                                 input logic [PW-1:0] rp);
        fill_level = wp - rp;
    endfunction : fill_level

    // Free-space class of a fill level
    function automatic dcf_pkg::dcf_room_e room_class(input logic [PW-1:0] lvl);
        logic [PW-1:0] room;
        room = PW'(DEPTH) - lvl;
        if (room == '0) begin
            room_class = dcf_pkg::DCF_ROOM_FULL;
        end else if (room == PW'(1)) begin
            room_class = dcf_pkg::DCF_ROOM_FULL1;
        end else if (room == PW'(2)) begin
            room_class = dcf_pkg::DCF_ROOM_FULL2;
        end else begin
            room_class = dcf_pkg::DCF_ROOM_OPEN;
        end
    endfunction : room_class

    // ==========================================================
    // Registers and nets
    logic [DW-1:0]     mem_ff [DEPTH];   // Main memory
    logic [PW-1:0]     wr_ptr_ff;        // Accepted-word pointer
    logic [PW-1:0]     nxt_wr_ptr;       // Its next value
    logic [PW-1:0]     mem_wp_ff;        // Words committed to memory
    logic [PW-1:0]     rd_ptr_ff;        // Words moved to output register
    logic [PW-1:0]     nxt_rd_ptr;       // Its next value
    logic [PW-1:0]     rd_ptr_a;         // Read pointer seen by write side
    logic [PW-1:0]     wr_ptr_b;         // Write pointer seen by read side
    logic [DW-1:0]     out_word_ff;      // FIFO output register
    logic              out_ready_ff;     // Output register holds a new word
    logic              in_ready_ff;      // Memory has a free location
    logic              ae_n_ff;          // Almost-empty flag, low active
    logic              af_n_ff;          // Almost-full flag, low active
    logic [DW-1:0]     a_to_b_mailbox;   // Mailbox written from port A
    logic [DW-1:0]     b_to_a_mailbox;   // Mailbox written from port B
    logic              a_to_b_mailbox_n_ff;       // First mail flag
    logic              b_to_a_mailbox_n_ff;       // Second mail flag
    dcf_pkg::dcf_room_e room_a;          // Write-side comparator class
    logic              a_sel;            // Port A cycle enabled
    logic              b_sel;            // Port B cycle enabled
    logic              a_fifo_wr;        // FIFO write taken
    logic              a_mail_wr;        // First mailbox write
    logic              a_mail_rd;        // Second mailbox read
    logic              b_fifo_rd;        // FIFO read selected
    logic              b_mail_wr;        // Second mailbox write
    logic              b_mail_rd;        // First mailbox read
    logic              word_avail;       // Memory holds the next word
    logic              load_out;         // Next word moves to output register

    dcf_stream_if #(.W(DW)) st_in  ();   // Into the staging buffer
    dcf_stream_if #(.W(DW)) st_out ();   // Out to the main memory

    // ==========================================================
    // Port decode
    always_comb begin
        a_sel     = !port_a_chip_select_n && port_a_enable;
        b_sel     = !port_b_chip_select_n && port_b_enable;
        // Write only with room in memory and in the staging buffer
        a_fifo_wr = a_sel && port_a_write_not_read && !port_a_mailbox_select
                    && in_ready_ff && st_in.ready;
        a_mail_wr = a_sel && port_a_write_not_read && port_a_mailbox_select;
        a_mail_rd = a_sel && !port_a_write_not_read && port_a_mailbox_select;
        b_fifo_rd = b_sel && port_b_read_not_write && !port_b_mailbox_select;
        b_mail_wr = b_sel && !port_b_read_not_write && port_b_mailbox_select;
        b_mail_rd = b_sel && port_b_read_not_write && port_b_mailbox_select;
    end

    // ==========================================================
    // Data bus drive
    always_comb begin
        a_data_oe  = !port_a_chip_select_n && !port_a_write_not_read;
        a_data_out = b_to_a_mailbox;
        b_data_oe  = !port_b_chip_select_n && port_b_read_not_write;
        // Mailbox select picks first mailbox, else the output register
        if (port_b_mailbox_select) begin
            b_data_out = a_to_b_mailbox;
        end else begin
            b_data_out = out_word_ff;
        end
    end

    // ==========================================================
    // Write path: staging buffer then main memory
    assign st_in.data   = a_data_in;
    assign st_in.valid  = a_fifo_wr;
    // Memory never overruns words not yet read out
    assign st_out.ready = fill_level(mem_wp_ff, rd_ptr_ff) != PW'(DEPTH);

    dcf_word_fifo #(
        .W (DW),
        .D (STAGE)
    ) u_stage (
        .clk   (clk),
        .rst   (rst),
        .s_in  (st_in),
        .s_out (st_out)
    );

    // Memory write from the staging buffer
    always_ff @(posedge clk) begin
        if (st_out.valid && st_out.ready) begin
            mem_ff[mem_wp_ff[AW-1:0]] <= st_out.data;
        end
    end

    // Accepted and committed write pointers
    assign nxt_wr_ptr = wr_ptr_ff + PW'(a_fifo_wr);

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            mem_wp_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            mem_wp_ff <= mem_wp_ff + PW'(st_out.valid && st_out.ready);
        end
    end

    // ==========================================================
    // Pointer hand-over between the two sides
    dcf_ptr_delay #(.W(PW)) u_rd_to_a (
        .clk     (clk),
        .rst     (rst),
        .ptr_in  (rd_ptr_ff),
        .ptr_out (rd_ptr_a)
    );

    dcf_ptr_delay #(.W(PW)) u_wr_to_b (
        .clk     (clk),
        .rst     (rst),
        .ptr_in  (wr_ptr_ff),
        .ptr_out (wr_ptr_b)
    );

    // ==========================================================
    // Read path: output register
    always_comb begin
        // Word must be seen by the read side and present in memory
        word_avail = (fill_level(wr_ptr_b, rd_ptr_ff) != '0)
                     && (fill_level(mem_wp_ff, rd_ptr_ff) != '0);
        // Empty register fills itself; full one only on a FIFO read
        load_out   = word_avail && (!out_ready_ff || b_fifo_rd);
        nxt_rd_ptr = rd_ptr_ff + PW'(load_out);
    end

    // Read pointer moves when a word enters the output register
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr_ff <= '0;
        end else begin
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    // Output register and output-ready
    always_ff @(posedge clk) begin
        if (rst) begin
            out_word_ff  <= dcf_pkg::RST_WORD;
            out_ready_ff <= dcf_pkg::RST_OUTPUT_READY;
        end else if (load_out) begin
            out_word_ff  <= mem_ff[rd_ptr_ff[AW-1:0]];
            out_ready_ff <= 1'b1;
        end else if (b_fifo_rd && out_ready_ff) begin
            // Word consumed with nothing behind it; data kept
            out_ready_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Write-side flags, second stage after the read pointer hand-over
    assign room_a = room_class(fill_level(nxt_wr_ptr, rd_ptr_a));

    always_ff @(posedge clk) begin
        if (rst) begin
            in_ready_ff <= dcf_pkg::RST_INPUT_READY;
        end else begin
            unique case (room_a)
                dcf_pkg::DCF_ROOM_FULL:  in_ready_ff <= 1'b0;
                dcf_pkg::DCF_ROOM_FULL1: in_ready_ff <= 1'b1;
                dcf_pkg::DCF_ROOM_FULL2: in_ready_ff <= 1'b1;
                dcf_pkg::DCF_ROOM_OPEN:  in_ready_ff <= 1'b1;
            endcase
        end
    end

    // Almost-full: low at depth minus Y words or more
    always_ff @(posedge clk) begin
        if (rst) begin
            af_n_ff <= dcf_pkg::RST_FLAG_N;
        end else begin
            af_n_ff <= fill_level(nxt_wr_ptr, rd_ptr_a)
                       < (PW'(DEPTH) - almost_full_offset);
        end
    end

    // ==========================================================
    // Read-side flag: almost-empty high above X words
    always_ff @(posedge clk) begin
        if (rst) begin
            ae_n_ff <= dcf_pkg::RST_FLAG_N;
        end else begin
            ae_n_ff <= fill_level(wr_ptr_b, nxt_rd_ptr) > almost_empty_offset;
        end
    end

    // ==========================================================
    // Mailboxes; a write, taken only while the mailbox is empty, wins over a read in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            a_to_b_mailbox <= dcf_pkg::RST_WORD;
            a_to_b_mailbox_n_ff     <= dcf_pkg::RST_MAIL_FLAG_N;
        end else if (a_mail_wr && a_to_b_mailbox_n_ff) begin
            a_to_b_mailbox <= a_data_in;
            a_to_b_mailbox_n_ff     <= 1'b0;
        end else if (b_mail_rd) begin
            a_to_b_mailbox_n_ff     <= 1'b1;
        end
    end

    // Second mailbox, written from port B and read on port A
    always_ff @(posedge clk) begin
        if (rst) begin
            b_to_a_mailbox <= dcf_pkg::RST_WORD;
            b_to_a_mailbox_n_ff     <= dcf_pkg::RST_MAIL_FLAG_N;
        end else if (b_mail_wr && b_to_a_mailbox_n_ff) begin
            b_to_a_mailbox <= b_data_in;
            b_to_a_mailbox_n_ff     <= 1'b0;
        end else if (a_mail_rd) begin
            b_to_a_mailbox_n_ff     <= 1'b1;
        end
    end

    // ==========================================================
    // Flag outputs
    always_comb begin
        input_ready_flag    = in_ready_ff && st_in.ready;
        output_ready_flag   = out_ready_ff;
        almost_empty_flag_n = ae_n_ff;
        almost_full_flag_n  = af_n_ff;
        first_mail_flag_n   = a_to_b_mailbox_n_ff;
        second_mail_flag_n  = b_to_a_mailbox_n_ff;
    end
endmodule : dcf_top
`default_nettype wire

// File: src/dcf_pkg.sv
// Shared constants and types for the two-port clocked FIFO block
package dcf_pkg;
    // ==========================================================
    // Geometry
    localparam int unsigned DATA_W        = 36;   // Word width on both ports
    localparam int unsigned DEPTH_DEFAULT = 512;  // Main memory depth in words
    localparam int unsigned STAGE_DEPTH   = 16;   // Write staging buffer depth
    // ==========================================================
    // Reset values
    localparam logic RST_INPUT_READY  = 1'b0;  // No writes until flags settle
    localparam logic RST_OUTPUT_READY = 1'b0;  // Output register holds no word
    localparam logic RST_FLAG_N       = 1'b0;  // Almost flags reset low
    localparam logic RST_MAIL_FLAG_N  = 1'b1;  // Mailboxes reset empty
    localparam logic [DATA_W-1:0] RST_WORD = 36'h0_0000_0000;  // Register data reset
    // ==========================================================
    // Timing: pointer stages between the two sides of the memory
    localparam int unsigned PTR_DELAY_STAGES = 1;  // Stage before the flag flop
    // ==========================================================
    // Free-space classes of the write-side pointer comparator
    typedef enum logic [3:0] {
        DCF_ROOM_FULL  = 4'h1,  // No free location
        DCF_ROOM_FULL1 = 4'h2,  // One below full
        DCF_ROOM_FULL2 = 4'h4,  // Two below full
        DCF_ROOM_OPEN  = 4'h8   // Three or more free
    } dcf_room_e;
endpackage : dcf_pkg

// File: src/dcf_stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/1ns
`default_nettype none
interface dcf_stream_if #(parameter int unsigned W = 36);
    logic [W-1:0] data;   // Word carried
    logic         valid;  // Source offers a word
    logic         ready;  // Sink takes the word
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : dcf_stream_if
`default_nettype wire

// File: src/dcf_word_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dcf_word_fifo #(
    parameter int unsigned W = 36,
    parameter int unsigned D = 16
) (
    input  wire logic  clk,
    input  wire logic  rst,
    dcf_stream_if.snk  s_in,
    dcf_stream_if.src  s_out
);
    localparam int unsigned AW = $clog2(D);

    // ==========================================================
    // Parameter check
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("dcf_word_fifo: depth must be a power of two of at least 2");
    end

    logic [W-1:0]  mem_ff [D];  // Storage
    logic [AW:0]   wp_ff;       // Write pointer with wrap bit
    logic [AW:0]   rp_ff;       // Read pointer with wrap bit
    logic          push;        // Word taken in
    logic          pop;         // Word handed out

    // Honest full and empty from the pointer difference
    assign s_in.ready  = (wp_ff - rp_ff) != (AW+1)'(D);
    assign s_out.valid = wp_ff != rp_ff;
    assign s_out.data  = mem_ff[rp_ff[AW-1:0]];
    assign push        = s_in.valid && s_in.ready;
    assign pop         = s_out.valid && s_out.ready;

    // ==========================================================
    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wp_ff[AW-1:0]] <= s_in.data;
        end
    end

    // ==========================================================
    // Pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= wp_ff + (AW+1)'(push);
            rp_ff <= rp_ff + (AW+1)'(pop);
        end
    end
endmodule : dcf_word_fifo
`default_nettype wire

// File: src/dcf_ptr_delay.sv
// Pointer hand-over stage between the write and read sides of the memory
`timescale 1ns/1ns
`default_nettype none
module dcf_ptr_delay #(
    parameter int unsigned W = 10
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] ptr_in,
    output var  logic [W-1:0] ptr_out
);
    // First of the two stages; the flag flop that reads it is the second
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_out <= '0;
        end else begin
            ptr_out <= ptr_in;
        end
    end
endmodule : dcf_ptr_delay
`default_nettype wire

// File: dv/dcf_top_chk.sv
// Concurrent checks on the two-port FIFO decode and flag timing
`timescale 1ns/1ns
`default_nettype none
module dcf_top_chk #(
    parameter int unsigned DEPTH = 512,
    parameter int unsigned PW    = 10
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          port_a_chip_select_n,
    input wire logic          port_a_write_not_read,
    input wire logic          port_a_enable,
    input wire logic          port_a_mailbox_select,
    input wire logic          a_data_oe,
    input wire logic          port_b_chip_select_n,
    input wire logic          port_b_read_not_write,
    input wire logic          port_b_enable,
    input wire logic          port_b_mailbox_select,
    input wire logic          b_data_oe,
    input wire logic [PW-1:0] almost_empty_offset,
    input wire logic [PW-1:0] almost_full_offset,
    input wire logic          input_ready_flag,
    input wire logic          output_ready_flag,
    input wire logic          almost_empty_flag_n,
    input wire logic          almost_full_flag_n,
    input wire logic          first_mail_flag_n,
    input wire logic          second_mail_flag_n
);
    // ==========================================================
    // Word count model: accepted writes minus words loaded to the output register
    logic        wr_go, rd_go, ld, a_mw, a_mr, b_mw, b_mr;  // Events at the coming edge; ld is the load at the last edge
    logic        wr_ff, rd_ff, or_ff;                       // Events of the last edge
    logic [15:0] cnt_ff, cur;                               // Count before and after last edge
    assign wr_go = !port_a_chip_select_n && port_a_write_not_read && port_a_enable
                   && !port_a_mailbox_select && input_ready_flag;
    assign rd_go = !port_b_chip_select_n && port_b_read_not_write && port_b_enable
                   && !port_b_mailbox_select && output_ready_flag;
    assign a_mw  = !port_a_chip_select_n && port_a_write_not_read && port_a_enable && port_a_mailbox_select;
    assign a_mr  = !port_a_chip_select_n && !port_a_write_not_read && port_a_enable && port_a_mailbox_select;
    assign b_mw  = !port_b_chip_select_n && !port_b_read_not_write && port_b_enable && port_b_mailbox_select;
    assign b_mr  = !port_b_chip_select_n && port_b_read_not_write && port_b_enable && port_b_mailbox_select;
    // A load is a fall-through or a read that brought the next word
    assign ld    = output_ready_flag && (!or_ff || rd_ff);
    assign cur   = cnt_ff + {15'h0, wr_ff} - {15'h0, ld};
    // Event history, cleared by reset
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ff  <= 1'b0;
            rd_ff  <= 1'b0;
            or_ff  <= 1'b0;
            cnt_ff <= 16'h0;
        end else begin
            wr_ff  <= wr_go;
            rd_ff  <= rd_go;
            or_ff  <= output_ready_flag;
            cnt_ff <= cur;
        end
    end
    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Properties
    a_drive_on_a: assert property (a_data_oe == (!port_a_chip_select_n && !port_a_write_not_read))
        else $error("port A drive enable wrong");
    b_drive_on_a: assert property (b_data_oe == (!port_b_chip_select_n && port_b_read_not_write))
        else $error("port B drive enable wrong");
    mail_two_read_a: assert property ((a_mr && !b_mw) |=> second_mail_flag_n)
        else $error("second mail flag not set by port A read");
    mail_one_read_a: assert property ((b_mr && !a_mw) |=> first_mail_flag_n)
        else $error("first mail flag not set by port B read");
    no_overfill_a: assert property (input_ready_flag |-> cur < 16'(DEPTH))
        else $error("input ready high with memory full");
    empty_rise_a: assert property ((wr_ff && !ld && !almost_empty_flag_n && cur == 16'(almost_empty_offset) + 16'h1) ##1 !ld |-> !almost_empty_flag_n ##1 (almost_empty_flag_n || ld))
        else $error("almost empty rise not on second edge");
    full_rise_a: assert property ((ld && !wr_ff && !almost_full_flag_n && cur == 16'(DEPTH) - 16'(almost_full_offset) - 16'h1) ##1 !wr_ff |-> !almost_full_flag_n ##1 (almost_full_flag_n || wr_ff))
        else $error("almost full rise not on second edge");
    ready_rise_a: assert property ((ld && !input_ready_flag && cur == 16'(DEPTH) - 16'h1) |=> !input_ready_flag ##1 input_ready_flag)
        else $error("input ready rise not on second edge");
endmodule : dcf_top_chk
bind dcf_top dcf_top_chk #(.DEPTH(DEPTH), .PW(PW)) u_dcf_top_chk (.*);
`default_nettype wire

// File: dv/dcf_b_master.sv
// Port B bus master model: FIFO reads and mailbox traffic
`timescale 1ns/1ns
`default_nettype none
module dcf_b_master (
    input  wire logic        clk,
    input  wire logic        output_ready_flag,
    input  wire logic [35:0] b_data_out,
    output var  logic        port_b_chip_select_n,
    output var  logic        port_b_read_not_write,
    output var  logic        port_b_enable,
    output var  logic        port_b_mailbox_select,
    output var  logic [35:0] b_data_in
);
    initial begin
        port_b_chip_select_n  = 1'b1;
        port_b_read_not_write = 1'b1;
        port_b_enable         = 1'b0;
        port_b_mailbox_select = 1'b0;
        b_data_in             = 36'h0_0000_0000;
    end
    // Set selects with no operation enabled
    task automatic b_sel(input logic cs_n, input logic rnw);
        port_b_chip_select_n  = cs_n;
        port_b_read_not_write = rnw;
        port_b_enable         = 1'b0;
    endtask : b_sel
    // Idle cycles; released data shows the inverse of its last value
    task automatic b_idle(input int n);
        port_b_enable = 1'b0;
        b_data_in     = ~b_data_in;
        repeat (n) begin @(posedge clk); #1; end
    endtask : b_idle
    // FIFO read held until an edge with output ready, mailbox read at the next edge; word taken at that edge
    task automatic b_read(input logic mb, output logic [35:0] d, output logic ok);
        int n = 0;
        port_b_chip_select_n  = 1'b0;
        port_b_read_not_write = 1'b1;
        port_b_enable         = 1'b1;
        port_b_mailbox_select = mb;
        @(negedge clk);
        while (!mb && !output_ready_flag && n < 40) begin @(negedge clk); n++; end
        ok = (n < 40);
        d  = b_data_out;
        @(posedge clk); #1;
    endtask : b_read
    // Second mailbox write
    task automatic b_write(input logic [35:0] w);
        port_b_chip_select_n  = 1'b0;
        port_b_read_not_write = 1'b0;
        port_b_enable         = 1'b1;
        port_b_mailbox_select = 1'b1;
        b_data_in             = w;
        @(posedge clk); #1;
        port_b_enable         = 1'b0;
    endtask : b_write
endmodule : dcf_b_master
`default_nettype wire

// File: dv/dcf_top_test.sv
// Self-checking bench for the two-port FIFO
`timescale 1ns/1ns
`default_nettype none
module dcf_top_test;
    localparam int unsigned DEPTH = 512;
    localparam int unsigned PW    = 10;
    localparam int unsigned DW    = dcf_pkg::DATA_W;
    localparam int          XO    = 8;  // Almost-empty offset used
    localparam int          YO    = 8;  // Almost-full offset used
    logic          clk = 1'b0, rst = 1'b1;
    logic          port_a_chip_select_n, port_a_write_not_read;
    logic          port_a_enable, port_a_mailbox_select;
    logic [DW-1:0] a_data_in, a_data_out, b_data_in, b_data_out, rd_w;
    logic          a_data_oe, b_data_oe, port_b_chip_select_n, port_b_read_not_write;
    logic          port_b_enable, port_b_mailbox_select, input_ready_flag, output_ready_flag;
    logic          almost_empty_flag_n, almost_full_flag_n, first_mail_flag_n, second_mail_flag_n;
    logic [PW-1:0] almost_empty_offset = 10'h008, almost_full_offset = 10'h008;
    logic          ok;
    logic [5:0]    rows [4] = '{6'b000111, 6'b010000, 6'b101100, 6'b001010};
    int            err_total = 0, num_checks = 0, rd_idx;
    always #5 clk = ~clk;
    dcf_top #(.DEPTH(DEPTH)) u_dcf_top (.*);
    dcf_b_master u_dcf_b_master (.*);
    function automatic logic [DW-1:0] wd(input int i);
        return {4'ha, 32'(i)};
    endfunction : wd
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    // Port A operation held for one edge; FIFO writes wait for input ready first
    task automatic a_op(input logic wr, input logic mb, input logic [DW-1:0] w);
        int n = 0;
        port_a_chip_select_n  = 1'b0;
        port_a_write_not_read = wr;
        port_a_enable         = 1'b1;
        port_a_mailbox_select = mb;
        a_data_in             = w;
        @(negedge clk);
        while (wr && !mb && !input_ready_flag && n < 200) begin @(negedge clk); n++; end
        if (n == 200) begin err_total++; complete_run(); end
        @(posedge clk); #1;
    endtask : a_op
    task automatic a_idle(input int n);
        port_a_enable = 1'b0;
        a_data_in     = ~a_data_in;
        repeat (n) begin @(posedge clk); #1; end
    endtask : a_idle
    task automatic b_take(input int idx);
        u_dcf_b_master.b_read(1'b0, rd_w, ok);
        chk(rd_w, wd(idx));
    endtask : b_take
    initial begin
        // Port A deselected and idle while reset is held
        {port_a_chip_select_n, port_a_write_not_read} = 2'b11;
        {port_a_enable, port_a_mailbox_select}        = 2'b00;
        a_data_in                                     = 36'h0_0000_0000;
        repeat (10) begin @(posedge clk); #1; end
        chk(36'({input_ready_flag, output_ready_flag, almost_empty_flag_n}), 36'h0);
        chk(36'({almost_full_flag_n, first_mail_flag_n, second_mail_flag_n}), 36'h3);
        rst = 1'b0;
        a_idle(3);
        $display("test reset done");
        foreach (rows[i]) begin
            port_a_chip_select_n  = rows[i][5];
            port_a_write_not_read = rows[i][4];
            u_dcf_b_master.b_sel(rows[i][3], rows[i][2]);
            @(posedge clk); #1;
            chk(36'(a_data_oe), 36'(rows[i][1]));
            chk(36'(b_data_oe), 36'(rows[i][0]));
        end
        $display("test decode table done");
        a_op(1'b1, 1'b1, 36'h1_2345_6789);
        chk(36'(first_mail_flag_n), 36'h0);
        a_op(1'b1, 1'b1, 36'h0_5555_aaaa);
        a_idle(1);
        u_dcf_b_master.b_read(1'b1, rd_w, ok);
        chk(rd_w, 36'h1_2345_6789);
        chk(36'(first_mail_flag_n), 36'h1);
        u_dcf_b_master.b_write(36'h0_abcd_ef01);
        chk(36'(second_mail_flag_n), 36'h0);
        a_op(1'b0, 1'b1, 36'h0);
        chk(a_data_out, 36'h0_abcd_ef01);
        chk(36'(second_mail_flag_n), 36'h1);
        a_idle(1);
        $display("test mailboxes done");
        // Fill with port B stalled: the output register frees one location
        for (int i = 0; i <= DEPTH; i++) begin
            a_op(1'b1, 1'b0, wd(i));
            if (i == XO || i == XO + 1) begin
                a_idle(4);
                chk(36'(almost_empty_flag_n), 36'(i == XO + 1));
            end
        end
        a_idle(4);
        chk(36'({input_ready_flag, almost_full_flag_n}), 36'h0);
        port_a_enable = 1'b1;
        a_data_in     = 36'hf_ffff_ffff;
        repeat (3) begin @(posedge clk); #1; end
        a_idle(1);
        b_take(0);
        chk(36'(input_ready_flag), 36'h0);
        u_dcf_b_master.b_idle(1);
        chk(36'(input_ready_flag), 36'h0);
        u_dcf_b_master.b_idle(1);
        chk(36'(input_ready_flag), 36'h1);
        a_op(1'b1, 1'b0, wd(DEPTH + 1));
        a_idle(4);
        $display("test fill done");
        for (rd_idx = 1; rd_idx <= YO; rd_idx++) b_take(rd_idx);
        u_dcf_b_master.b_idle(4);
        chk(36'(almost_full_flag_n), 36'h0);
        b_take(rd_idx);
        rd_idx++;
        u_dcf_b_master.b_idle(4);
        chk(36'(almost_full_flag_n), 36'h1);
        for (; rd_idx <= DEPTH + 1; rd_idx++) begin
            b_take(rd_idx);
            if (rd_idx % 3 == 0) u_dcf_b_master.b_idle(2);
        end
        u_dcf_b_master.b_idle(4);
        chk(36'(output_ready_flag), 36'h0);
        u_dcf_b_master.b_read(1'b0, rd_w, ok);
        chk(36'(ok), 36'h0);
        chk(b_data_out, wd(DEPTH + 1));
        u_dcf_b_master.b_idle(2);
        $display("test drain done");
        complete_run();
    end
endmodule : dcf_top_test
`default_nettype wire
